// ---- hw/picr_pkg.sv ----
// constants and state types for the posted interrupt clear registers
package picr_pkg;
    // ==========================================================
    // bank layout
    localparam int BANK_W = 8;
    localparam int NUM_BANKS = 3;
    localparam int IDX_W = 10;
    localparam int ADDR_W = 12;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] IDX_SYS_CLR = 10'h0da;
    localparam logic [9:0] IDX_DIG_CLR = 10'h0db;
    localparam logic [9:0] IDX_MOD_CLR = 10'h0dc;
    localparam logic [9:0] IDX_MASK3 = 10'h0de;
    localparam logic [2:0][9:0] BANK_IDX = {IDX_MOD_CLR, IDX_DIG_CLR, IDX_SYS_CLR};
    // ==========================================================
    // defined bits per bank; system bank bit 3 is unused
    localparam logic [7:0] SYS_DEF_MASK = 8'hf7;
    localparam logic [7:0] DIG_DEF_MASK = 8'hff;
    localparam logic [7:0] MOD_DEF_MASK = 8'hff;
    localparam logic [2:0][7:0] BANK_DEF = {MOD_DEF_MASK, DIG_DEF_MASK, SYS_DEF_MASK};
    localparam logic [7:0] POSTED_RESET = 8'h00;
    // system bank source positions
    localparam int VARCLK3_BIT = 7;
    localparam int SLEEP_BIT = 6;
    localparam int PIN_BIT = 5;
    localparam int UNDERVOLTAGE_LOCKOUT_SRC_SRC_BIT = 4;
    localparam int ANALOG1_BIT = 2;
    localparam int ANALOG0_BIT = 1;
    localparam int VMON_BIT = 0;
    // modulator bank source positions
    localparam int MOD_LOW_BIT = 7;
    localparam int MOD_HIGH_BIT = 6;
    // ==========================================================
    // third mask register
    localparam int SWEN_BIT = 7;
    localparam logic SWEN_RESET = 1'b0;
    // ==========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] posted;
    } picr_bank_state_type;

    typedef struct packed {
        logic awGot;
        logic wGot;
        logic [9:0] wrIdx;
        logic [7:0] wrData;
        logic wrLane;
        logic bValid;
        logic [1:0] bResp;
        logic awReady;
        logic wReady;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic swEn;
    } picr_top_state_type;
endpackage

// ---- hw/picr_bank_if.sv ----
// link between the register front end and one posted-interrupt bank
`timescale 1ns/1ns
`default_nettype none
interface picr_bank_if;
    logic wrStb;
    logic [7:0] wrData;
    logic swEn;
    logic clearAll;
    logic [7:0] srcEvt;
    logic [7:0] posted;
    modport ctrl (output wrStb, output wrData, output swEn, output clearAll,
                  output srcEvt, input posted);
    modport bank (input wrStb, input wrData, input swEn, input clearAll,
                  input srcEvt, output posted);
endinterface
`default_nettype wire

// ---- hw/picr_post_bank.sv ----
// one eight-bit bank of posted interrupt flags
`timescale 1ns/1ns
`default_nettype none
module picr_post_bank
    import picr_pkg::*;
#(
    parameter logic [7:0] DEF_MASK = 8'hff
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous, active high
    picr_bank_if.bank port // strobes in, posted flags out
);
    picr_bank_state_type state_reg;
    picr_bank_state_type state_next;
    logic [7:0] setVec;
    logic [7:0] clrVec;

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        setVec = port.srcEvt;
        if (port.wrStb && port.swEn) begin
            setVec = setVec | port.wrData;
        end
        clrVec = 8'h00;
        if (port.wrStb && !port.swEn) begin
            clrVec = ~port.wrData;
        end
        if (port.clearAll) begin
            clrVec = 8'hff;
        end
        // set wins over clear; clearing an idle flag changes nothing
        state_next.posted = ((state_reg.posted & ~clrVec) | setVec) & DEF_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= '{posted: POSTED_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign port.posted = state_reg.posted;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_soft_post: assert property (
        (port.wrStb && port.swEn) |=>
            ((port.posted & $past(port.wrData) & DEF_MASK) == ($past(port.wrData) & DEF_MASK)))
        else $error("software post did not set flag");
    a_zero_clears: assert property (
        (port.wrStb && !port.swEn) |=>
            ((port.posted & ~$past(port.wrData) & ~$past(port.srcEvt)) == 8'h00))
        else $error("zero write did not clear flag");
    a_ones_keep: assert property (
        (port.wrStb && !port.clearAll) |=>
            (($past(port.posted) & ~port.posted &
              ($past(port.swEn) ? ~$past(port.wrData) | $past(port.wrData) : $past(port.wrData)))
             == ($past(port.swEn) ? 8'h00 : 8'h00)))
        else $error("write changed a flag it must keep");
    a_event_sets: assert property (
        1'b1 |=> ((port.posted & $past(port.srcEvt)) == ($past(port.srcEvt) & DEF_MASK)))
        else $error("hardware event lost");
    a_idle_hold: assert property (
        (!port.wrStb && !port.clearAll && port.srcEvt == 8'h00) |=> $stable(port.posted))
        else $error("flags moved without cause");
    a_reserved_zero: assert property (
        (port.posted & ~DEF_MASK) == 8'h00)
        else $error("unused bit set");
endmodule
`default_nettype wire

// ---- hw/picr_top.sv ----
// register front end for the three posted interrupt clear registers
//
// Notes on behaviour
// - reading a clear register shows 1 where the source has a posted interrupt
// - with software posting off, a 0 bit clears that flag only
// - clearing a flag that is not posted changes nothing
// - with software posting on, a 1 bit posts that source's interrupt
// - 1 with posting off, or 0 with posting on, leaves the flag
// - system bank: clock3, sleep, pins, undervoltage, -, analog1, analog0, monitor
// - digital bank: comm r1p3,r1p2, basic r1p1,r1p0, comm r0p3,r0p2, basic r0p1,r0p0
// - modulator bank: low prio, high prio, then comparators 13 down to 8
// - all defined bits are read/write and come out of reset as 0
// - bit 7 of the third mask register turns software posting on
// - masking never stops a flag from being posted
`timescale 1ns/1ns
`default_nettype none
module picr_top
    import picr_pkg::*;
(
    input wire logic core_clk, // 50 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [23:0] srcEvent, // one-cycle source events, bank 0 in low byte
    input wire logic clearAllReq, // controller-wide clear of posted flags
    output logic [23:0] postedIrq, // posted flags, bank 0 in low byte
    output logic softIrqEnable // software posting enable
);
    picr_top_state_type state_reg;
    picr_top_state_type state_next;
    logic [23:0] postedAll;
    logic wrFire;
    logic [NUM_BANKS-1:0] bankWr;
    logic [9:0] rdIdx;

    picr_bank_if bankIf[NUM_BANKS] ();

    // ==========================================================
    // banks
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : gBank
            assign bankIf[g].wrStb = bankWr[g];
            assign bankIf[g].wrData = state_reg.wrData;
            assign bankIf[g].swEn = state_reg.swEn;
            assign bankIf[g].clearAll = clearAllReq;
            // unused system position never receives an event
            assign bankIf[g].srcEvt = srcEvent[g*BANK_W +: BANK_W] & BANK_DEF[g];
            assign postedAll[g*BANK_W +: BANK_W] = bankIf[g].posted;
            assign bankWr[g] = wrFire && state_reg.wrLane && (state_reg.wrIdx == BANK_IDX[g]);
            picr_post_bank #(
                .DEF_MASK(BANK_DEF[g])
            ) picr_post_bank_inst (
                .core_clk(core_clk),
                .reset(reset),
                .port(bankIf[g])
            );
        end
    endgenerate

    assign wrFire = state_reg.awGot && state_reg.wGot && !state_reg.bValid;
    assign rdIdx = s_axi_araddr[11:2];

    // ==========================================================
    // decode helpers
    function automatic logic idxMapped(input logic [9:0] idx);
        logic hit;
        hit = (idx == IDX_MASK3);
        for (int b = 0; b < NUM_BANKS; b++) begin
            hit = hit | (idx == BANK_IDX[b]);
        end
        return hit;
    endfunction

    function automatic logic [31:0] readWord(input logic [9:0] idx, input logic [23:0] flags,
                                             input logic en);
        logic [31:0] word;
        word = RDATA_ZERO;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (idx == BANK_IDX[b]) begin
                word[7:0] = flags[b*BANK_W +: BANK_W];
            end
        end
        if (idx == IDX_MASK3) begin
            word[SWEN_BIT] = en;
        end
        return word;
    endfunction

    // ==========================================================
    // bus slave next state
    always_comb begin
        state_next = state_reg;
        if (s_axi_awvalid && state_reg.awReady) begin
            state_next.awGot = 1'b1;
            state_next.wrIdx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && state_reg.wReady) begin
            state_next.wGot = 1'b1;
            state_next.wrData = s_axi_wdata[7:0];
            state_next.wrLane = s_axi_wstrb[0];
        end
        if (state_reg.bValid && s_axi_bready) begin
            state_next.bValid = 1'b0;
        end
        if (wrFire) begin
            state_next.awGot = 1'b0;
            state_next.wGot = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp = idxMapped(state_reg.wrIdx) ? RESP_OKAY : RESP_SLVERR;
            if (state_reg.wrLane && state_reg.wrIdx == IDX_MASK3) begin
                state_next.swEn = state_reg.wrData[SWEN_BIT];
            end
        end
        state_next.awReady = !state_next.awGot && !state_next.bValid;
        state_next.wReady = !state_next.wGot && !state_next.bValid;
        if (state_reg.rValid && s_axi_rready) begin
            state_next.rValid = 1'b0;
        end
        if (s_axi_arvalid && state_reg.arReady) begin
            state_next.rValid = 1'b1;
            state_next.rData = readWord(rdIdx, postedAll, state_reg.swEn);
            state_next.rResp = idxMapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
        end
        state_next.arReady = !state_next.rValid;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= '{
                awGot: 1'b0,
                wGot: 1'b0,
                wrIdx: 10'h000,
                wrData: 8'h00,
                wrLane: 1'b0,
                bValid: 1'b0,
                bResp: RESP_OKAY,
                awReady: 1'b0,
                wReady: 1'b0,
                arReady: 1'b0,
                rValid: 1'b0,
                rData: RDATA_ZERO,
                rResp: RESP_OKAY,
                swEn: SWEN_RESET
            };
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready = state_reg.awReady;
    assign s_axi_wready = state_reg.wReady;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_arready = state_reg.arReady;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rdata = state_reg.rData;
    assign s_axi_rresp = state_reg.rResp;
    assign postedIrq = postedAll;
    assign softIrqEnable = state_reg.swEn;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence sAddrTaken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence sDataTaken;
        s_axi_wvalid && s_axi_wready;
    endsequence

    a_write_resp: assert property (
        (sAddrTaken and sDataTaken) |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    a_read_data: assert property (
        (s_axi_arvalid && s_axi_arready && rdIdx == IDX_SYS_CLR) |=>
            (s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(postedAll[7:0])}))
        else $error("read of system bank wrong");
    a_swen_write: assert property (
        (wrFire && state_reg.wrLane && state_reg.wrIdx == IDX_MASK3) |=>
            (softIrqEnable == $past(state_reg.wrData[SWEN_BIT])))
        else $error("software enable not updated");
    a_unmapped_err: assert property (
        (wrFire && !idxMapped(state_reg.wrIdx)) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
        else $error("unmapped write not refused");
    a_resp_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped early");
    a_reset_clear: assert property (
        $fell(reset) |-> (postedIrq == 24'h00_0000 && !softIrqEnable))
        else $error("state not zero after reset");
endmodule
`default_nettype wire

// ---- tb/picr_bench.sv ----
// self-checking bench for the posted interrupt clear registers
`timescale 1ns/1ns
`default_nettype none
module picr_bench
    import picr_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic clearAllReq = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [23:0] srcEvent = 24'h00_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic softIrqEnable;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [23:0] postedIrq;
    int errors = 0;
    int num_checks = 0;
    integer seed = 32'h7eef;
    logic [23:0] expFlags = 24'h00_0000;
    logic expEn = 1'b0;
    logic [33:0] rdQ[$];
    logic [1:0] wrQ[$];
    localparam logic [11:0] MASK_ADDR = {IDX_MASK3, 2'b00};

    always #10 core_clk = ~core_clk;

    picr_top picr_top_inst (.core_clk(core_clk), .reset(reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .srcEvent(srcEvent),
        .clearAllReq(clearAllReq), .postedIrq(postedIrq), .softIrqEnable(softIrqEnable));

    // ==========================================================
    // comparison and closing
    task check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task timed_out;
        errors++;
        $display("wrong value handshake expected answer seen timeout");
        give_verdict();
    endtask

    // ==========================================================
    // bus master
    task axi_write(input logic [11:0] addr, input logic [7:0] data, input logic [3:0] strb,
                   input logic [1:0] resp);
        int n;
        wrQ.push_back(resp);
        @(posedge core_clk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h00_0000, data};
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 200) timed_out();
    endtask

    task axi_read(input logic [11:0] addr, input logic [33:0] exp);
        int n;
        rdQ.push_back(exp);
        @(posedge core_clk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 200) timed_out();
    endtask

    // ==========================================================
    // answer watcher
    always @(posedge core_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            if (rdQ.size() == 0) check("unexpected read", 34'h0_0000_0000, 34'h3_ffff_ffff);
            else check("read answer", {s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) begin
            if (wrQ.size() == 0) check("unexpected write", 34'h0_0000_0000, 34'h3_ffff_ffff);
            else check("write response", 34'(s_axi_bresp), 34'(wrQ.pop_front()));
        end
    end

    // ==========================================================
    // helpers
    task read_bank(input int k);
        axi_read({BANK_IDX[k], 2'b00},
                 {RESP_OKAY, 24'h00_0000, expFlags[8*k +: 8]});
    endtask

    task read_all;
        for (int k = 0; k < NUM_BANKS; k++) read_bank(k);
        axi_read(MASK_ADDR, {RESP_OKAY, 24'h00_0000, expEn, 7'h00});
        #1;
        check("posted flags", {10'h000, postedIrq}, {10'h000, expFlags});
        check("soft enable", {33'h0_0000_0000, softIrqEnable}, {33'h0_0000_0000, expEn});
    endtask

    task pulse_events(input logic [23:0] ev);
        @(posedge core_clk);
        srcEvent <= ev;
        @(posedge core_clk);
        srcEvent <= 24'h00_0000;
        expFlags = expFlags | (ev & BANK_DEF);
    endtask

    task bank_round(input logic post);
        logic [7:0] d;
        for (int k = 0; k < NUM_BANKS; k++) begin
            pulse_events(24'($random(seed)));
            d = 8'($random(seed)) & BANK_DEF[k];
            axi_write({BANK_IDX[k], 2'b00}, d, 4'h1, RESP_OKAY);
            if (post) expFlags[8*k +: 8] = expFlags[8*k +: 8] | d;
            else expFlags[8*k +: 8] = expFlags[8*k +: 8] & d;
            read_bank(k);
            #1;
            check("flags after write", {10'h000, postedIrq}, {10'h000, expFlags});
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        read_all();
        $display("test reset values done");
        pulse_events(24'hff_ffff);
        read_all();
        $display("test event posting done");
        repeat (6) bank_round(1'b0);
        read_all();
        $display("test clearing writes done");
        axi_write(MASK_ADDR, 8'h80, 4'h1, RESP_OKAY);
        expEn = 1'b1;
        @(posedge core_clk);
        clearAllReq <= 1'b1;
        @(posedge core_clk);
        clearAllReq <= 1'b0;
        expFlags = 24'h00_0000;
        read_all();
        repeat (6) bank_round(1'b1);
        $display("test software posting done");
        axi_write({IDX_SYS_CLR, 2'b00}, 8'hf7, 4'h0, RESP_OKAY);
        axi_write(MASK_ADDR, 8'h00, 4'h1, RESP_OKAY);
        expEn = 1'b0;
        axi_write({IDX_DIG_CLR, 2'b00}, 8'h00, 4'h0, RESP_OKAY);
        axi_write(12'h374, 8'h00, 4'h1, RESP_SLVERR);
        axi_read(12'h000, {RESP_SLVERR, RDATA_ZERO});
        read_all();
        $display("test strobes and unmapped done");
        // mid-run reset with flags and enable up must bring both back to zero
        axi_write(MASK_ADDR, 8'h80, 4'h1, RESP_OKAY);
        expEn = 1'b1;
        pulse_events(24'($random(seed)));
        read_all();
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        expFlags = 24'h00_0000;
        expEn = 1'b0;
        repeat (2) @(posedge core_clk);
        read_all();
        $display("test mid-run reset done");
        repeat (3) @(posedge core_clk);
        give_verdict();
    end
endmodule
`default_nettype wire
